/* hw/sbit_pkg.sv */
// Purpose: Shared constants and types for the sixteen-bit interval timer
// Assumes: Registers sit on the core's 8-bit I/O space
// Notes:   Counter and prescaler widths are fixed
package sbit_pkg;

  // I/O addresses
  localparam logic [7:0] MODE_ADDR      = 8'h06;
  localparam logic [7:0] EDGE_ADDR      = 8'h0C;
  localparam int         EDGE_BIT       = 5;

  // Values after reset
  localparam logic [7:0]  MODE_RST      = 8'h00;
  localparam logic [7:0]  EDGE_RST      = 8'h00;
  localparam logic [15:0] COUNT_RST     = 16'h0000;
  localparam logic [5:0]  PRESC_RST     = 6'h00;

  // Mode field positions
  localparam int SRC_HI = 7;
  localparam int SRC_LO = 5;
  localparam int DIV_HI = 4;
  localparam int DIV_LO = 3;
  localparam int BIT_HI = 2;
  localparam int BIT_LO = 0;
  localparam int IRQ_BIT_BASE = 8;

  // Clock source codes
  localparam logic [2:0] SRC_STOP = 3'h0;
  localparam logic [2:0] SRC_CORE = 3'h1;
  localparam logic [2:0] SRC_FAST = 3'h4;
  localparam logic [2:0] SRC_XTAL = 3'h5;
  localparam logic [2:0] SRC_SLOW = 3'h6;
  localparam logic [2:0] SRC_PIN  = 3'h7;

  // Prescaler masks for /1, /4, /16, /64
  localparam logic [5:0] DIV1_MASK  = 6'h00;
  localparam logic [5:0] DIV4_MASK  = 6'h03;
  localparam logic [5:0] DIV16_MASK = 6'h0F;
  localparam logic [5:0] DIV64_MASK = 6'h3F;

  // Core I/O request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sbit_io_req_s;

  // Counter instruction request
  typedef struct packed {
    logic        load;
    logic        read;
    logic [15:0] data;
  } sbit_cnt_req_s;

endpackage

/* hw/sbit_timer.sv */
// Purpose: Sixteen-bit up counter with source select, prescaler, bit-edge request
// Assumes: Oscillator and pin inputs are asynchronous to REF_CLK_I
// Notes:   Async sources are sampled, so they must run well below 40 MHz
//
// What this block does
// RL1: Mode bits 7..5 choose the counting source
// RL2: Mode bits 4..3 prescale by 1/4/16/64
// RL3: Mode bits 2..0 pick counter bit 8..15
// RL4: Sixteen-bit counter only counts up by one
// RL5: Load instruction writes new count from memory
// RL6: Read instruction copies count, counting unaffected
// RL7: Edge register bit 5 picks request edge
// RL8: Free run: one request per 2^(n+1) ticks
// RL9: Pin source counts pin pulses
// RL10: Wraps past all ones; unused codes halt
// RL11: Pin synchronised before edge detection
`timescale 1ns/1ps
module sbit_timer (
  // Clock and reset
  input  wire logic                    REF_CLK_I,
  input  wire logic                    RST_I,
  // Asynchronous clock sources
  input  wire logic                    FAST_OSC_I,
  input  wire logic                    XTAL_OSC_I,
  input  wire logic                    SLOW_OSC_I,
  input  wire logic                    PIN_CLK_I,
  // Core I/O port
  input  wire sbit_pkg::sbit_io_req_s  IO_REQ_I,
  output logic [7:0]                   IO_RDATA_O,
  // Counter instructions
  input  wire sbit_pkg::sbit_cnt_req_s CNT_REQ_I,
  output logic [15:0]                  READ_DATA_O,
  // Interrupt request pulse
  output logic                         IRQ_O
);

  logic [7:0]  mode_r;
  logic [7:0]  edge_r;
  logic [15:0] count_r;
  logic [15:0] count_prev_r;
  logic [5:0]  presc_r;
  logic [3:0]  s1_r;
  logic [3:0]  s2_r;
  logic [3:0]  s3_r;
  logic [3:0]  lvl_r;
  logic [3:0]  lvl_prev_r;
  logic [3:0]  rise_w;
  logic        tick_w;
  logic        inc_w;
  logic [5:0]  mask_w;
  logic [2:0]  sel_w;
  logic        bit_now_w;
  logic        bit_old_w;
  logic        irq_nxt;

  function automatic logic [5:0] div_mask(input logic [1:0] code);
    case (code)
      2'd0:    div_mask = sbit_pkg::DIV1_MASK;
      2'd1:    div_mask = sbit_pkg::DIV4_MASK;
      2'd2:    div_mask = sbit_pkg::DIV16_MASK;
      default: div_mask = sbit_pkg::DIV64_MASK;
    endcase
  endfunction

  // Registers
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      mode_r <= sbit_pkg::MODE_RST;
      edge_r <= sbit_pkg::EDGE_RST;
    end
    else if (IO_REQ_I.wr)
    begin
      if (IO_REQ_I.addr == sbit_pkg::MODE_ADDR)
        mode_r <= IO_REQ_I.wdata; // RL1
      if (IO_REQ_I.addr == sbit_pkg::EDGE_ADDR)
        edge_r <= IO_REQ_I.wdata; // RL7
    end
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
      IO_RDATA_O <= 8'h00;
    else if (IO_REQ_I.rd && IO_REQ_I.addr == sbit_pkg::MODE_ADDR)
      IO_RDATA_O <= mode_r;
    else if (IO_REQ_I.rd && IO_REQ_I.addr == sbit_pkg::EDGE_ADDR)
      IO_RDATA_O <= edge_r;
    else if (IO_REQ_I.rd)
      IO_RDATA_O <= 8'h00;
  end

  // Three-stage synchronisers; a level counts once stages two and three agree
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      s1_r       <= 4'h0;
      s2_r       <= 4'h0;
      s3_r       <= 4'h0;
      lvl_r      <= 4'h0;
      lvl_prev_r <= 4'h0;
    end
    else
    begin
      s1_r       <= {PIN_CLK_I, SLOW_OSC_I, XTAL_OSC_I, FAST_OSC_I}; // RL11
      s2_r       <= s1_r;
      s3_r       <= s2_r;
      lvl_r      <= (s2_r & s3_r) | (lvl_r & (s2_r | s3_r)); // RL11
      lvl_prev_r <= lvl_r;
    end
  end

  assign rise_w = lvl_r & ~lvl_prev_r;

  // Source mux; unused codes give no tick
  always_comb
  begin
    case (mode_r[sbit_pkg::SRC_HI:sbit_pkg::SRC_LO])
      sbit_pkg::SRC_CORE: tick_w = 1'b1; // RL1
      sbit_pkg::SRC_FAST: tick_w = rise_w[0];
      sbit_pkg::SRC_XTAL: tick_w = rise_w[1];
      sbit_pkg::SRC_SLOW: tick_w = rise_w[2];
      sbit_pkg::SRC_PIN:  tick_w = rise_w[3]; // RL9
      default:            tick_w = 1'b0; // RL10
    endcase
  end

  // Prescaler passes one tick in every 1, 4, 16 or 64
  assign mask_w = div_mask(mode_r[sbit_pkg::DIV_HI:sbit_pkg::DIV_LO]);
  assign inc_w  = tick_w && ((presc_r & mask_w) == mask_w); // RL2

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
      presc_r <= sbit_pkg::PRESC_RST;
    else if (tick_w)
      presc_r <= presc_r + 6'h01; // RL2
  end

  // Counter; a load wins over a coincident increment
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
      count_r <= sbit_pkg::COUNT_RST;
    else if (CNT_REQ_I.load)
      count_r <= CNT_REQ_I.data; // RL5
    else if (inc_w)
      count_r <= count_r + 16'h0001; // RL4 RL10
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
      READ_DATA_O <= 16'h0000;
    else if (CNT_REQ_I.read)
      READ_DATA_O <= count_r; // RL6
  end

  // Request from the chosen bit; comparing against the old count with the
  // same select avoids a false edge when the select is rewritten
  assign sel_w     = mode_r[sbit_pkg::BIT_HI:sbit_pkg::BIT_LO];
  assign bit_now_w = count_r[sbit_pkg::IRQ_BIT_BASE + int'(sel_w)]; // RL3
  assign bit_old_w = count_prev_r[sbit_pkg::IRQ_BIT_BASE + int'(sel_w)];
  assign irq_nxt   = edge_r[sbit_pkg::EDGE_BIT] ? (bit_old_w && !bit_now_w)
                                                : (!bit_old_w && bit_now_w); // RL7 RL8

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      count_prev_r <= sbit_pkg::COUNT_RST;
      IRQ_O        <= 1'b0;
    end
    else
    begin
      count_prev_r <= count_r;
      IRQ_O        <= irq_nxt; // RL8
    end
  end

  // Checks
  mode_write_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // RL1
    IO_REQ_I.wr && IO_REQ_I.addr == sbit_pkg::MODE_ADDR |=> mode_r == $past(IO_REQ_I.wdata))
    else $error("mode register not written");
  // Checked by spacing rather than by the mask, so a wrong mask cannot hide
  presc_div_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // RL2
    inc_w && mode_r[sbit_pkg::DIV_HI:sbit_pkg::DIV_LO] == 2'h1
    |=> (!inc_w || mode_r[sbit_pkg::DIV_HI:sbit_pkg::DIV_LO] != 2'h1) [*3])
    else $error("prescaler let a tick through early");
  count_up_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // RL4
    !CNT_REQ_I.load && inc_w |=> count_r == $past(count_r) + 16'h0001)
    else $error("counter did not step up by one");
  count_hold_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // RL4
    !CNT_REQ_I.load && !inc_w |=> $stable(count_r))
    else $error("counter moved without a tick");
  count_load_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // RL5
    CNT_REQ_I.load |=> count_r == $past(CNT_REQ_I.data))
    else $error("load value not taken");
  count_wrap_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // RL10
    !CNT_REQ_I.load && inc_w && count_r == 16'hFFFF |=> count_r == sbit_pkg::COUNT_RST)
    else $error("counter did not wrap to zero");
  edge_write_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // RL7
    IO_REQ_I.wr && IO_REQ_I.addr == sbit_pkg::EDGE_ADDR |=> edge_r == $past(IO_REQ_I.wdata))
    else $error("edge register not written");
  edge_read_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // RL7
    IO_REQ_I.rd && IO_REQ_I.addr == sbit_pkg::EDGE_ADDR |=> IO_RDATA_O == $past(edge_r))
    else $error("edge register read back wrong");
  count_read_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // RL6
    CNT_REQ_I.read |=> READ_DATA_O == $past(count_r))
    else $error("read data wrong");
  irq_edge_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // RL7
    IRQ_O |-> $past(bit_now_w) != $past(edge_r[sbit_pkg::EDGE_BIT]))
    else $error("request on the wrong edge");
  stop_halt_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // RL10
    mode_r[7:6] == 2'b00 && mode_r[5] == 1'b0 || mode_r[7:5] inside {3'h2, 3'h3}
    |-> !inc_w)
    else $error("halted source still counts");
  irq_pulse_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I) // RL8
    IRQ_O && !$past(CNT_REQ_I.load) && $stable(mode_r) && $stable(edge_r) |=> !IRQ_O)
    else $error("request held without new edge");

endmodule

/* tb/sbit_timer_bench.sv */
// Purpose: Self-checking bench for the sixteen-bit interval timer
// Assumes: One clock; each source input has its own stimulus line
// Notes:   Periods are timed between two requests, so the first one can be partial
`timescale 1ns/1ps
module sbit_timer_bench;
  logic                    clk       = 1'b0;
  logic                    rst       = 1'b1;
  logic [3:0]              osc       = 4'h0;
  sbit_pkg::sbit_io_req_s  ioq       = '0;
  sbit_pkg::sbit_cnt_req_s cq        = '0;
  logic [7:0]              iod;
  logic [15:0]             rd;
  logic                    irq;
  int                      n_errors  = 0;
  int                      cmp_count = 0;

  always #4 clk = ~clk;

  sbit_timer dut (.REF_CLK_I(clk), .RST_I(rst), .FAST_OSC_I(osc[0]), .XTAL_OSC_I(osc[1]),
    .SLOW_OSC_I(osc[2]), .PIN_CLK_I(osc[3]), .IO_REQ_I(ioq), .IO_RDATA_O(iod),
    .CNT_REQ_I(cq), .READ_DATA_O(rd), .IRQ_O(irq));

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  // Register access: write when w is high, read otherwise
  task automatic io(logic w, logic [7:0] a, logic [7:0] d);
    @(posedge clk) ioq <= '{w, !w, a, d};
    @(posedge clk) ioq <= '0;
    #1;
  endtask

  // Counter instruction: load when l is high, read otherwise
  task automatic cnt(logic l, logic [15:0] d);
    @(posedge clk) cq <= '{l, !l, d};
    @(posedge clk) cq <= '0;
    #1;
  endtask

  task automatic wait_irq(output int c);
    c = 0;
    do
    begin
      @(posedge clk);
      #1;
      c++;
    end while (irq !== 1'b1 && c < 70000);
  endtask

  // Pulse the inputs in hot: high for four cycles and low for five, then synchroniser room
  task automatic pulses(int n, logic [3:0] hot);
    repeat (n)
    begin
      @(posedge clk) osc <= hot;
      repeat (4) @(posedge clk);
      osc <= 4'h0;
      repeat (4) @(posedge clk);
    end
    repeat (8) @(posedge clk);
  endtask

  task automatic t_regs;
    cnt(0, 16'h0000);
    chk("count", sbit_pkg::COUNT_RST, rd);
    io(0, sbit_pkg::MODE_ADDR, 8'h00);
    chk("mode", {8'h00, sbit_pkg::MODE_RST}, {8'h00, iod});
    io(1, sbit_pkg::MODE_ADDR, 8'h2B);
    io(1, 8'h07, 8'h55);
    io(0, sbit_pkg::MODE_ADDR, 8'h00);
    chk("mode", 16'h002B, {8'h00, iod});
    io(0, 8'h07, 8'h00);
    chk("unmapped", 16'h0000, {8'h00, iod});
    io(1, sbit_pkg::EDGE_ADDR, 8'h20);
    io(0, sbit_pkg::EDGE_ADDR, 8'h00);
    chk("edge", 16'h0020, {8'h00, iod});
  endtask

  // f is the expected delay to the first request, or 0 where the prescaler phase is unknown
  task automatic t_per(logic [7:0] m, logic [7:0] e, int p, int f);
    int c;
    io(1, sbit_pkg::MODE_ADDR, 8'h00);
    io(1, sbit_pkg::EDGE_ADDR, e);
    cnt(1, 16'h00F0);
    io(1, sbit_pkg::MODE_ADDR, m);
    wait_irq(c);
    if (f > 0)
      chk("first", f[15:0], c[15:0]);
    wait_irq(c);
    chk("period", p[15:0], c[15:0]);
  endtask

  // Each oscillator and pin source counts only its own input; unused and stop codes count nothing
  task automatic t_src;
    logic [2:0] s [7] = '{3'h4, 3'h5, 3'h6, 3'h7, 3'h0, 3'h2, 3'h3};
    logic [3:0] hot;
    io(1, sbit_pkg::MODE_ADDR, 8'h00);
    for (int i = 0; i < 7; i++)
    begin
      hot = (s[i] >= 3'h4) ? 4'h1 << s[i][1:0] : 4'hF;
      cnt(1, 16'h0100);
      io(1, sbit_pkg::MODE_ADDR, {s[i], 5'h00});
      pulses(3, ~hot);
      pulses(3, hot);
      cnt(0, 16'h0000);
      chk("count", (s[i] >= 3'h4) ? 16'h0103 : 16'h0100, rd);
    end
  endtask

  task automatic t_wrap;
    io(1, sbit_pkg::MODE_ADDR, 8'h00);
    cnt(1, 16'hFFFF);
    io(1, sbit_pkg::MODE_ADDR, 8'hE0);
    pulses(2, 4'h8);
    cnt(0, 16'h0000);
    chk("wrap", 16'h0001, rd);
  endtask

  // Mid-run reset must return the count, mode and edge registers to their values after reset
  task automatic t_rst;
    @(posedge clk) rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    cnt(0, 16'h0000);
    chk("count", sbit_pkg::COUNT_RST, rd);
    io(0, sbit_pkg::MODE_ADDR, 8'h00);
    chk("mode", {8'h00, sbit_pkg::MODE_RST}, {8'h00, iod});
    io(0, sbit_pkg::EDGE_ADDR, 8'h00);
    chk("edge", {8'h00, sbit_pkg::EDGE_RST}, {8'h00, iod});
  endtask

  task automatic test_done;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    for (int i = 0; i < 4; i++) t_per(8'h20 | 8'(i << 3), 8'h00, 512 << (2 * i), 0);
    for (int i = 0; i < 4; i++) t_per(8'h20 | 8'(i), 8'h00, 512 << i, 0);
    t_per(8'h20, 8'h00, 512, 17);
    t_per(8'h20, 8'h20, 512, 273);
    t_src;
    t_wrap;
    t_rst;
    test_done;
  end

  // The scenarios take about 58000 cycles
  initial
  begin
    repeat (90000) @(posedge clk);
    n_errors++;
    test_done;
  end
endmodule
